/* daisy_chain_frame_stat_counters_tb.sv */
// Purpose: Self-checking bench for the frame statistics counters
// Assumes: One wait cycle per access, trigger reads return zero
// Notes:   Table rows are {address, expected byte}
`timescale 1ns/100ps
module daisy_chain_frame_stat_counters_tb;
    logic        clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [9:0]  avs_address_i;
    logic [31:0] avs_readdata_o;
    logic        hs_rx_frame_done_i, hs_rx_frame_ok_i, ls_rx_resp_good_i, hs_tx_resp_sent_i;
    int          mismatches, tests_run;
    logic [17:0] rows [14] = '{18'h27500, 18'h27700, 18'h28000, 18'h27701, 18'h27802,
        18'h27600, 18'h28100, 18'h27500, 18'h27603, 18'h27900, 18'h27A05, 18'h28100,
        18'h27600, 18'h3FF00};

    dcs_stat_top dut_u (.clk_i, .rstn_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i(32'hFFFF_FFFF), .avs_byteenable_i(4'hF), .avs_readdata_o,
        .avs_waitrequest_o, .hs_rx_frame_done_i, .hs_rx_frame_ok_i, .ls_rx_resp_good_i,
        .hs_tx_resp_sent_i);
    dcs_nbr_model nbr_u (.clk_i, .done_o(hs_rx_frame_done_i), .ok_o(hs_rx_frame_ok_i),
        .resp_o(ls_rx_resp_good_i), .sent_o(hs_tx_resp_sent_i));

    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_write_i   <= wr;
        avs_read_i    <= !wr;
        // Sample at rising edges only; release at the edge that sees the answer
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        tests_run++;
        if (n >= 20 || (!wr && avs_readdata_o !== {24'h000000, e})) begin
            mismatches++;
            $display("Error readdata at %h expected %h seen %h", a, e, avs_readdata_o);
        end
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task results;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // About 66k cycles of traffic fit well inside this span
    initial begin
        #3_000_000;
        mismatches++;
        results;
    end

    initial begin
        {rstn_i, avs_read_i, avs_write_i} = 3'h0;
        avs_address_i = 10'h000;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        nbr_u.send(0, 2, 1'b1);
        nbr_u.send(0, 1, 1'b0);
        nbr_u.send(0, 1, 1'b1);
        nbr_u.send(1, 258, 1'b1);
        nbr_u.send(2, 5, 1'b1);
        foreach (rows[i]) bus(1'b0, rows[i][17:8], rows[i][7:0]);
        $display("Table test done");
        bus(1'b1, 10'h27A, 8'h00);
        bus(1'b0, 10'h27A, 8'h00);
        $display("Write test done");
        nbr_u.send(2, 65537, 1'b1);
        bus(1'b0, 10'h281, 8'h00);
        bus(1'b0, 10'h279, 8'hFF);
        bus(1'b0, 10'h27A, 8'hFF);
        $display("Saturation test done");
        nbr_u.send(1, 3, 1'b1);
        rstn_i <= 1'b0;
        @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(1'b0, 10'h280, 8'h00);
        bus(1'b0, 10'h278, 8'h00);
        $display("Reset test done");
        results;
    end
endmodule

bind dcs_stat_top dcs_stat_chk chk_u (.clk_i, .rstn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .hs_rx_frame_done_i,
    .hs_rx_frame_ok_i, .ls_rx_resp_good_i, .hs_tx_resp_sent_i);

/* dcs_consts.svh */
// Purpose: Shared constants for the daisy-chain frame statistics counters
// Assumes: Register indices are word addresses on the register bus
// Notes:   Byte address of a register is four times its index
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// Counter geometry
`define DCS_CNT_WIDTH          16
`define DCS_BYTE_WIDTH         8
`define DCS_ADDR_WIDTH         10
`define DCS_DATA_WIDTH         32
`define DCS_NUM_CNT            3

// Register indices (word addresses)
`define DCS_UP_RX_GOOD_HI_IDX  10'h275
`define DCS_UP_RX_GOOD_LO_IDX  10'h276
`define DCS_LO_RX_RESP_HI_IDX  10'h277
`define DCS_LO_RX_RESP_LO_IDX  10'h278
`define DCS_UP_TX_RESP_HI_IDX  10'h279
`define DCS_UP_TX_RESP_LO_IDX  10'h27A
`define DCS_LO_SNAP_TRIG_IDX   10'h280
`define DCS_UP_SNAP_TRIG_IDX   10'h281

// Reset values and count constants
`define DCS_CNT_RESET          16'h0000
`define DCS_CNT_ALL_ONES       16'hFFFF
`define DCS_CNT_ONE            16'h0001
`define DCS_RDATA_ZERO         32'h0000_0000

`endif

/* dcs_nbr_model.sv */
// Purpose: Neighbouring stacked device producing frame events
// Assumes: Events are one-cycle pulses on the device clock
// Notes:   send() drives back-to-back frames of one kind
`timescale 1ns/100ps
module dcs_nbr_model (
    input  wire logic clk_i,  // Device clock
    output logic      done_o, // High-side frame ended
    output logic      ok_o,   // That frame was clean
    output logic      resp_o, // Low-side response arrived
    output logic      sent_o  // High-side response left
);
    initial begin
        {done_o, ok_o, resp_o, sent_o} = 4'h0;
    end

    // Kind 0 high-side receive, 1 low-side response, 2 high-side send
    task automatic send(input int k, input int n, input logic ok);
        repeat (n) begin
            @(posedge clk_i);
            done_o <= (k == 0);
            ok_o   <= ok;
            resp_o <= (k == 1);
            sent_o <= (k == 2);
        end
        @(posedge clk_i);
        {done_o, resp_o, sent_o} <= 3'h0;
        ok_o <= !ok; // Flip the qualifier so a stale level cannot help
    endtask
endmodule

/* dcs_pkg.sv */
// Purpose: Types for the daisy-chain frame statistics counters
// Assumes: Constants come from dcs_consts.svh
// Notes:   Holds types only
package dcs_pkg;

    // Bus slave handshake state
    typedef enum logic [0:0] {
        DCS_BUS_IDLE = 1'b0,
        DCS_BUS_ACK  = 1'b1
    } dcs_bus_state_type;

    // Counter channel numbering
    typedef enum logic [1:0] {
        DCS_CH_UP_RX_GOOD = 2'h0,
        DCS_CH_LO_RX_RESP = 2'h1,
        DCS_CH_UP_TX_RESP = 2'h2
    } dcs_channel_type;

endpackage

/* dcs_sat_counter.sv */
// Purpose: Saturating frame counter with a snapshot register
// Assumes: inc_i and snap_i are one-cycle pulses on clk_i
// Notes:   A snapshot copies the live count out and restarts the live count
`timescale 1ns/100ps
`include "dcs_consts.svh"

module dcs_sat_counter #(
    parameter int WIDTH = `DCS_CNT_WIDTH
) (
    input  wire logic             clk_i,   // Device clock
    input  wire logic             rstn_i,  // Async reset, active low
    input  wire logic             inc_i,   // Qualifying frame seen
    input  wire logic             snap_i,  // Copy out and restart
    output logic [WIDTH-1:0]      snap_o   // Value seen by software
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic [WIDTH-1:0] snap_r;

    // Next live count; a frame in the snapshot cycle opens the new window
    always_comb begin
        if (snap_i) begin
            count_nxt = inc_i ? WIDTH'(`DCS_CNT_ONE) : WIDTH'(`DCS_CNT_RESET);
        end else if (inc_i && (count_r != WIDTH'(`DCS_CNT_ALL_ONES))) begin
            count_nxt = count_r + WIDTH'(`DCS_CNT_ONE);
        end else begin
            count_nxt = count_r;
        end
    end

    // Live counter starts from zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_r <= WIDTH'(`DCS_CNT_RESET);
        end else begin
            count_r <= count_nxt;
        end
    end

    // Software view changes only at a snapshot, so all bytes agree
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            snap_r <= WIDTH'(`DCS_CNT_RESET);
        end else if (snap_i) begin
            snap_r <= count_r;
        end
    end

    assign snap_o = snap_r;

endmodule

/* dcs_stat_chk.sv */
// Purpose: Assertions on the counter byte reads of dcs_stat_top
// Assumes: One bus access in flight; answer comes one cycle after taking
// Notes:   Shadow live and frozen counts mirror the device
`timescale 1ns/100ps
`include "dcs_consts.svh"
module dcs_stat_chk (
    input wire logic        clk_i,              // Device clock
    input wire logic        rstn_i,             // Async reset, active low
    input wire logic [9:0]  avs_address_i,      // Word address
    input wire logic        avs_read_i,         // Read request
    input wire logic        avs_write_i,        // Write request
    input wire logic [31:0] avs_readdata_o,     // Read data
    input wire logic        avs_waitrequest_o,  // Stall
    input wire logic        hs_rx_frame_done_i, // High-side frame
    input wire logic        hs_rx_frame_ok_i,   // Frame clean
    input wire logic        ls_rx_resp_good_i,  // Low-side response
    input wire logic        hs_tx_resp_sent_i   // High-side sent
);
    logic [15:0] live_r [3];
    logic [15:0] view_r [3];
    wire         take    = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    wire         trig_lo = take & avs_read_i & (avs_address_i == `DCS_LO_SNAP_TRIG_IDX);
    wire         trig_up = take & avs_read_i & (avs_address_i == `DCS_UP_SNAP_TRIG_IDX);
    wire [2:0]   snap    = {trig_up, trig_lo, trig_up};
    wire [2:0]   ev      = {hs_tx_resp_sent_i, ls_rx_resp_good_i,
                            hs_rx_frame_done_i & hs_rx_frame_ok_i};

    // Shadow counts; an event in the trigger cycle starts the new window
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 3; i++) begin
                live_r[i] <= 16'h0000;
                view_r[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (snap[i]) begin
                    view_r[i] <= live_r[i];
                    live_r[i] <= {15'h0000, ev[i]};
                end else if (ev[i] && live_r[i] != 16'hFFFF) begin
                    live_r[i] <= live_r[i] + 16'h0001;
                end
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // Byte read answered in the wait-low cycle, upper bits zero
    property rd_p(a, b);
        take && avs_read_i && avs_address_i == a |=> avs_readdata_o == {24'h000000, b};
    endproperty

    a_hs_good_hi: assert property (rd_p(`DCS_UP_RX_GOOD_HI_IDX, view_r[0][15:8]))
        else $error("high-side good count high byte wrong");
    a_hs_good_lo: assert property (rd_p(`DCS_UP_RX_GOOD_LO_IDX, view_r[0][7:0]))
        else $error("high-side good count low byte wrong");
    a_ls_resp_hi: assert property (rd_p(`DCS_LO_RX_RESP_HI_IDX, view_r[1][15:8]))
        else $error("low-side response count high byte wrong");
    a_ls_resp_lo: assert property (rd_p(`DCS_LO_RX_RESP_LO_IDX, view_r[1][7:0]))
        else $error("low-side response count low byte wrong");
    a_tx_sent_hi: assert property (rd_p(`DCS_UP_TX_RESP_HI_IDX, view_r[2][15:8]))
        else $error("high-side sent count high byte wrong");
    a_tx_sent_lo: assert property (rd_p(`DCS_UP_TX_RESP_LO_IDX, view_r[2][7:0]))
        else $error("high-side sent count low byte wrong");
    a_lo_trig_zero: assert property (rd_p(`DCS_LO_SNAP_TRIG_IDX, 8'h00))
        else $error("low-side trigger read not zero");
    a_up_trig_zero: assert property (rd_p(`DCS_UP_SNAP_TRIG_IDX, 8'h00))
        else $error("high-side trigger read not zero");

    c_trig_up: cover property (trig_up);
    c_sat: cover property (live_r[2] == 16'hFFFF && hs_tx_resp_sent_i);
    c_write: cover property (take && avs_write_i);
endmodule

/* dcs_stat_top.sv */
// Purpose: Daisy-chain frame statistics counters behind an Avalon-MM slave
// Assumes: Frame event inputs are one-cycle pulses synchronous to clk_i
// Notes:   Every access waits exactly one cycle; registers are read-only
`timescale 1ns/100ps
`include "dcs_consts.svh"

module dcs_stat_top #(
    parameter int CNT_WIDTH  = `DCS_CNT_WIDTH,
    parameter int ADDR_WIDTH = `DCS_ADDR_WIDTH
) (
    input  wire logic                       clk_i,              // 40 MHz device clock
    input  wire logic                       rstn_i,             // Async reset, active low
    input  wire logic [ADDR_WIDTH-1:0]      avs_address_i,      // Word address (index)
    input  wire logic                       avs_read_i,         // Read request
    input  wire logic                       avs_write_i,        // Write request
    input  wire logic [`DCS_DATA_WIDTH-1:0] avs_writedata_i,    // Write data, ignored
    input  wire logic [3:0]                 avs_byteenable_i,   // Byte lanes, ignored
    output logic [`DCS_DATA_WIDTH-1:0]      avs_readdata_o,     // Registered read data
    output logic                            avs_waitrequest_o,  // Stall until answer
    input  wire logic                       hs_rx_frame_done_i, // High-side frame ended
    input  wire logic                       hs_rx_frame_ok_i,   // That frame had no error
    input  wire logic                       ls_rx_resp_good_i,  // Low-side good response
    input  wire logic                       hs_tx_resp_sent_i   // High-side response sent
);

    localparam int NCH = `DCS_NUM_CNT;

    dcs_pkg::dcs_bus_state_type bus_state_r;
    dcs_pkg::dcs_bus_state_type bus_state_nxt;

    logic                        req_take;
    logic                        rd_take;
    logic                        ls_snap;
    logic                        hs_snap;
    logic [NCH-1:0]              ch_inc;
    logic [NCH-1:0]              ch_snap;
    logic [CNT_WIDTH-1:0]        ch_val [NCH];
    logic [`DCS_DATA_WIDTH-1:0]  rdata_nxt;
    logic [`DCS_DATA_WIDTH-1:0]  rdata_r;
    logic [`DCS_BYTE_WIDTH-1:0]  byte_sel;
    logic                        wr_ignored;

    // A request is taken only in the idle state; the answer comes a cycle later
    assign req_take = (bus_state_r == dcs_pkg::DCS_BUS_IDLE) && (avs_read_i || avs_write_i);
    assign rd_take  = req_take && avs_read_i;

    // Writes complete normally; they change no counter but clear the read data register
    assign wr_ignored = req_take && avs_write_i;

    // Trigger reads fire once per access, at the edge that takes them
    assign ls_snap = rd_take && (avs_address_i == ADDR_WIDTH'(`DCS_LO_SNAP_TRIG_IDX));
    assign hs_snap = rd_take && (avs_address_i == ADDR_WIDTH'(`DCS_UP_SNAP_TRIG_IDX));

    // Event qualification per channel
    assign ch_inc[dcs_pkg::DCS_CH_UP_RX_GOOD] = hs_rx_frame_done_i && hs_rx_frame_ok_i;
    assign ch_inc[dcs_pkg::DCS_CH_LO_RX_RESP] = ls_rx_resp_good_i;
    assign ch_inc[dcs_pkg::DCS_CH_UP_TX_RESP] = hs_tx_resp_sent_i;

    // Each port's trigger refreshes only that port's counters
    assign ch_snap[dcs_pkg::DCS_CH_UP_RX_GOOD] = hs_snap;
    assign ch_snap[dcs_pkg::DCS_CH_LO_RX_RESP] = ls_snap;
    assign ch_snap[dcs_pkg::DCS_CH_UP_TX_RESP] = hs_snap;

    // One saturating counter per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_cnt
            dcs_sat_counter #(
                .WIDTH (CNT_WIDTH)
            ) u_cnt (
                .clk_i  (clk_i),
                .rstn_i (rstn_i),
                .inc_i  (ch_inc[g]),
                .snap_i (ch_snap[g]),
                .snap_o (ch_val[g])
            );
        end
    endgenerate

    // Read decode; unmapped and trigger addresses read as zero
    always_comb begin
        byte_sel  = '0;
        rdata_nxt = `DCS_RDATA_ZERO;
        unique case (avs_address_i)
            ADDR_WIDTH'(`DCS_UP_RX_GOOD_HI_IDX): begin
                byte_sel = ch_val[dcs_pkg::DCS_CH_UP_RX_GOOD][15:8];
            end
            ADDR_WIDTH'(`DCS_UP_RX_GOOD_LO_IDX): begin
                byte_sel = ch_val[dcs_pkg::DCS_CH_UP_RX_GOOD][7:0];
            end
            ADDR_WIDTH'(`DCS_LO_RX_RESP_HI_IDX): begin
                byte_sel = ch_val[dcs_pkg::DCS_CH_LO_RX_RESP][15:8];
            end
            ADDR_WIDTH'(`DCS_LO_RX_RESP_LO_IDX): begin
                byte_sel = ch_val[dcs_pkg::DCS_CH_LO_RX_RESP][7:0];
            end
            ADDR_WIDTH'(`DCS_UP_TX_RESP_HI_IDX): begin
                byte_sel = ch_val[dcs_pkg::DCS_CH_UP_TX_RESP][15:8];
            end
            ADDR_WIDTH'(`DCS_UP_TX_RESP_LO_IDX): begin
                byte_sel = ch_val[dcs_pkg::DCS_CH_UP_TX_RESP][7:0];
            end
            default: begin
                byte_sel = '0;
            end
        endcase
        // Narrow data in the low lane, upper bits zero
        rdata_nxt = {{(`DCS_DATA_WIDTH-`DCS_BYTE_WIDTH){1'b0}}, byte_sel};
    end

    // Handshake state: idle, then one answer cycle with waitrequest low
    always_comb begin
        bus_state_nxt = bus_state_r;
        unique case (bus_state_r)
            dcs_pkg::DCS_BUS_IDLE: begin
                if (req_take) begin
                    bus_state_nxt = dcs_pkg::DCS_BUS_ACK;
                end
            end
            dcs_pkg::DCS_BUS_ACK: begin
                bus_state_nxt = dcs_pkg::DCS_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_state_r <= dcs_pkg::DCS_BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // Read data captured from the views as they stood before any snapshot
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= `DCS_RDATA_ZERO;
        end else if (rd_take) begin
            rdata_r <= rdata_nxt;
        end else if (wr_ignored) begin
            rdata_r <= `DCS_RDATA_ZERO;
        end
    end

    // Stall while a request waits to be taken; answer cycle never stalls
    assign avs_waitrequest_o = (bus_state_r == dcs_pkg::DCS_BUS_IDLE)
                               && (avs_read_i || avs_write_i);
    assign avs_readdata_o    = rdata_r;

endmodule
